//--- rtl/osr_receiver.sv
// serial host receiver: link front end, byte parser, buffer, storage
`timescale 1ns/1ps
`default_nettype none
module osr_receiver
    import osr_pkg::*;
#(
    parameter logic       SPI_MODE   = OSR_SPI_DEFAULT,
    parameter logic [7:0] CHIP_ADDR  = OSR_CHIP_ADDR,
    parameter int         FIFO_DEPTH = OSR_FIFO_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  ce,
    input  wire logic                  scl_pin,
    input  wire logic                  sda_pin_in,
    output logic                       sda_pin_out,
    output logic                       sda_pin_oe_n,
    input  wire logic                  ss_n_pin,
    input  wire logic                  rd_req,
    input  wire logic [OSR_ADDR_W-1:0] rd_addr,
    output logic [7:0]                 rd_data,
    output logic                       rd_valid,
    output logic                       display_enable_bit
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    generate
        if (FIFO_DEPTH < 2 || (1 << PW) != FIFO_DEPTH) begin : g_bad
            $error("buffer depth must be a power of two, at least two");
        end
    endgenerate

    // ************************************************************
    // decode helpers
    // ************************************************************
    // byte kind from the two top bits; 1x is any row or segment byte
    function automatic osr_kind_type osr_kind(input logic [7:0] b);
        if (b[7])
            return OSR_K_ROW;
        else if (b[7:6] == OSR_PFX_COLC)
            return OSR_K_COLC;
        else
            return OSR_K_COLAB;
    endfunction

    // storage block picked by the row/segment byte
    function automatic logic [1:0] osr_blk(input logic [7:0] b);
        if (b[7:6] == OSR_PFX_SEG)
            return OSR_BLK_FONT;
        else
            return b[OSR_ATTR_BIT] ? OSR_BLK_ATTR : OSR_BLK_DISP;
    endfunction

    // last column (or line) of a block, used for auto-increment wrap
    function automatic logic [4:0] osr_last(input logic [1:0] blk);
        case (blk)
            OSR_BLK_DISP: return OSR_DISP_LAST;
            OSR_BLK_ATTR: return OSR_ATTR_LAST;
            default:      return OSR_FONT_LAST;
        endcase
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pin_meta;  // first stage, read only by second
    logic [2:0] pin_sync;  // {scl, sda, ss_n} after two flops
    logic [2:0] pin_prev;  // one more stage for edge detection

    // serial clock is slow (160 ns and up), so plain sampling suffices
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_meta <= 3'h7;
            pin_sync <= 3'h7;
            pin_prev <= 3'h7;
        end else if (ce) begin
            pin_meta <= {scl_pin, sda_pin_in, ss_n_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic scl_s, sda_s, ss_s, scl_rise, scl_fall, start_c, stop_c;
    assign scl_s    = pin_sync[2];
    assign sda_s    = pin_sync[1];
    assign ss_s     = pin_sync[0];
    assign scl_rise = scl_s & ~pin_prev[2];
    assign scl_fall = ~scl_s & pin_prev[2];
    // start/stop: data moves while the clock stays high
    assign start_c  = scl_s & pin_prev[2] & pin_prev[1] & ~sda_s;
    assign stop_c   = scl_s & pin_prev[2] & ~pin_prev[1] & sda_s;

    // ************************************************************
    // link front end
    // ************************************************************
    osr_link_type lk;         // two-wire phase
    logic [7:0]   shreg;      // incoming bits, msb first
    logic [3:0]   bitcnt;     // clocks seen in this byte
    logic         ack_pend;   // byte earned an acknowledge
    logic         byte_valid; // whole byte waiting for parser
    logic [7:0]   byte_data;
    logic         end_pend;   // transfer end waiting for parser
    logic         byte_take, end_take;
    logic [7:0]   next_byte;
    assign next_byte = {shreg[6:0], sda_s};

    // one pin set serves both protocols, chosen at build time
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lk           <= OSR_LK_IDLE;
            shreg        <= 8'h00;
            bitcnt       <= 4'h0;
            ack_pend     <= 1'b0;
            byte_valid   <= 1'b0;
            byte_data    <= 8'h00;
            end_pend     <= 1'b0;
            sda_pin_oe_n <= 1'b1;
            sda_pin_out  <= 1'b0;
        end else if (ce) begin
            // clears first, so a fresh set below always wins
            if (byte_take)
                byte_valid <= 1'b0;
            if (end_take)
                end_pend <= 1'b0;
            if (SPI_MODE) begin
                // spi: no address, no acknowledge, select frames it
                if (ss_s) begin
                    bitcnt <= 4'h0;
                    if (!pin_prev[0])
                        end_pend <= 1'b1;
                end else if (scl_rise) begin
                    shreg <= next_byte;
                    if (bitcnt == OSR_LAST_BIT) begin
                        bitcnt     <= 4'h0;
                        byte_valid <= 1'b1;
                        byte_data  <= next_byte;
                    end else begin
                        bitcnt <= 4'(bitcnt + 4'h1);
                    end
                end
            end else if (start_c) begin
                lk       <= OSR_LK_ADDR;
                bitcnt   <= 4'h0;
                end_pend <= 1'b1;  // repeated start also restarts parse
            end else if (stop_c) begin
                lk           <= OSR_LK_IDLE;
                bitcnt       <= 4'h0;
                end_pend     <= 1'b1;
                ack_pend     <= 1'b0;
                sda_pin_oe_n <= 1'b1;
            end else if (lk != OSR_LK_IDLE) begin
                if (scl_rise) begin
                    if (bitcnt == OSR_ACK_BIT) begin
                        bitcnt <= 4'h0;
                    end else begin
                        shreg  <= next_byte;
                        bitcnt <= 4'(bitcnt + 4'h1);
                    end
                    if (bitcnt == OSR_LAST_BIT) begin
                        case (lk)
                            OSR_LK_ADDR: begin
                                // foreign address: stay silent
                                if (next_byte == CHIP_ADDR) begin
                                    ack_pend <= 1'b1;
                                    lk       <= OSR_LK_DATA;
                                end else begin
                                    lk <= OSR_LK_SKIP;
                                end
                            end
                            OSR_LK_DATA: begin
                                ack_pend   <= 1'b1;
                                byte_valid <= 1'b1;
                                byte_data  <= next_byte;
                            end
                            default: ;
                        endcase
                    end
                end
                // drive low across the ninth clock, release after it
                if (scl_fall) begin
                    if (bitcnt == OSR_ACK_BIT && ack_pend) begin
                        sda_pin_oe_n <= 1'b0;
                    end else if (bitcnt == 4'h0) begin
                        sda_pin_oe_n <= 1'b1;
                        ack_pend     <= 1'b0;
                    end
                end
            end
        end
    end

    // ************************************************************
    // byte parser
    // ************************************************************
    osr_parse_type ps;        // what the next byte must be
    logic [1:0]    blk;       // selected storage block
    logic [3:0]    row;       // row or segment
    logic [4:0]    col;       // column or line
    logic          data_phase, push, fifo_in_ready;
    osr_kind_type  kind;
    logic [4:0]    col_field;

    assign kind       = osr_kind(byte_data);
    assign col_field  = (blk == OSR_BLK_FONT) ? {1'b0, byte_data[3:0]}
                                               : byte_data[4:0];
    assign data_phase = (ps == OSR_PS_DATA) || (ps == OSR_PS_STREAM);
    // a data byte waits while the buffer is full: the link is far slower
    assign byte_take  = byte_valid && (!data_phase || fifo_in_ready);
    assign end_take   = end_pend && !byte_valid;
    assign push       = byte_take && data_phase;

    // stream length is unbounded until the transfer ends
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ps  <= OSR_PS_ROW;
            blk <= OSR_BLK_DISP;
            row <= 4'h0;
            col <= 5'h00;
        end else if (ce) begin
            if (end_take) begin
                ps <= OSR_PS_ROW;
            end else if (byte_take) begin
                case (ps)
                    OSR_PS_ROW: begin
                        if (kind == OSR_K_ROW) begin
                            blk <= osr_blk(byte_data);
                            row <= byte_data[3:0];
                            ps  <= OSR_PS_COL;
                        end
                    end
                    OSR_PS_COL, OSR_PS_AFTER: begin
                        case (kind)
                            OSR_K_ROW: begin  // back to format a
                                blk <= osr_blk(byte_data);
                                row <= byte_data[3:0];
                                ps  <= OSR_PS_COL;
                            end
                            OSR_K_COLAB: begin
                                col <= col_field;
                                ps  <= OSR_PS_DATA;
                            end
                            default: begin  // format c begins
                                col <= col_field;
                                ps  <= OSR_PS_STREAM;
                            end
                        endcase
                    end
                    OSR_PS_DATA: ps <= OSR_PS_AFTER;
                    OSR_PS_STREAM: begin
                        // wrap at the block's last column, next row
                        if (col == osr_last(blk)) begin
                            col <= 5'h00;
                            row <= 4'(row + 4'h1);
                        end else begin
                            col <= 5'(col + 5'h01);
                        end
                    end
                    default: ps <= OSR_PS_ROW;
                endcase
            end
        end
    end

    // ************************************************************
    // two-entry write buffer
    // ************************************************************
    osr_wr_type      fifo_mem [FIFO_DEPTH];
    logic [PW-1:0]   wptr, rptr;
    logic [PW:0]     fifo_cnt;
    logic            mem_we;
    osr_wr_type      head;

    assign fifo_in_ready = fifo_cnt != (PW+1)'(FIFO_DEPTH);
    assign head          = fifo_mem[rptr];
    // refresh reads own the storage; writes wait in the buffer
    assign mem_we        = (fifo_cnt != '0) && !rd_req;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wptr     <= '0;
            rptr     <= '0;
            fifo_cnt <= '0;
        end else if (ce) begin
            if (push) begin
                fifo_mem[wptr] <= '{addr: {blk, row, col}, data: byte_data};
                wptr           <= PW'(wptr + 1'b1);
            end
            if (mem_we)
                rptr <= PW'(rptr + 1'b1);
            fifo_cnt <= (PW+1)'(fifo_cnt + push - mem_we);
        end
    end

    // ************************************************************
    // storage and refresh read port
    // ************************************************************
    logic [7:0] store [OSR_MEM_WORDS];  // display, attribute, font

    always_ff @(posedge clk) begin
        if (ce && mem_we)
            store[head.addr] <= head.data;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= rd_req;
            if (rd_req)
                rd_data <= store[rd_addr];
        end
    end

    // screen output stays off until software raises the enable bit
    always_ff @(posedge clk) begin
        if (!reset_n)
            display_enable_bit <= 1'b0;
        else if (ce && mem_we &&
                 head.addr == {OSR_BLK_ATTR, OSR_CTRL_ROW, OSR_CTRL_COL})
            display_enable_bit <= head.data[OSR_EN_BIT];
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk iff ce); endclocking
    default disable iff (!reset_n);

    AST_ACK_DRIVE: assert property (
        !SPI_MODE && scl_fall && bitcnt == OSR_ACK_BIT && ack_pend
        && !stop_c |=> !sda_pin_oe_n)
        else $error("acknowledge not driven on ninth clock");
    AST_ACK_RELEASE: assert property (
        !sda_pin_oe_n && scl_fall && bitcnt == 4'h0 |=> sda_pin_oe_n)
        else $error("data line held past acknowledge");
    AST_FOREIGN_SILENT: assert property (
        lk == OSR_LK_SKIP |-> sda_pin_oe_n && !push)
        else $error("answered a foreign address");
    AST_SPI_DESELECT: assert property (
        SPI_MODE && ss_s |=> bitcnt == 4'h0 && !$rose(byte_valid))
        else $error("spi byte taken while deselected");
    AST_END_RESETS: assert property (
        end_take |=> ps == OSR_PS_ROW)
        else $error("parser not reset at transfer end");
    AST_STREAM_STAYS: assert property (
        ps == OSR_PS_STREAM && !end_take |=> ps == OSR_PS_STREAM)
        else $error("left auto-increment format mid transfer");
    AST_EXPLICIT: assert property (
        push && ps == OSR_PS_DATA |=> ps == OSR_PS_AFTER
        && fifo_cnt != '0)
        else $error("explicit data byte not queued");
    AST_AUTOINC: assert property (
        push && ps == OSR_PS_STREAM && col != osr_last(blk)
        |=> col == 5'($past(col) + 5'h01) && row == $past(row))
        else $error("auto-increment step wrong");
    AST_NO_COLLIDE: assert property (
        rd_req |-> !mem_we ##1 rd_valid)
        else $error("write collided with refresh read");

    COV_ACK: cover property (!sda_pin_oe_n ##1 sda_pin_oe_n);
    COV_STREAM: cover property (push && ps == OSR_PS_STREAM);
    COV_FULL: cover property (!fifo_in_ready && rd_req);
    COV_ENABLE: cover property ($rose(display_enable_bit));

endmodule
`default_nettype wire

//--- pkg/osr_pkg.sv
// constants and types shared by the on-screen display serial receiver
`default_nettype none
package osr_pkg;

    // ************************************************************
    // link framing
    // ************************************************************
    localparam logic [7:0] OSR_CHIP_ADDR   = 8'h7a; // default address byte
    localparam logic [3:0] OSR_LAST_BIT    = 4'h7;  // eighth data bit
    localparam logic [3:0] OSR_ACK_BIT     = 4'h8;  // ninth clock
    localparam int         OSR_MAX_BPS     = 100000; // host-side limit
    localparam logic       OSR_SPI_DEFAULT = 1'b0;  // two-wire standard

    // ************************************************************
    // byte prefixes and fields
    // ************************************************************
    localparam logic [1:0] OSR_PFX_ROW   = 2'h2; // 100 display, 101 attr
    localparam logic [1:0] OSR_PFX_SEG   = 2'h3; // font segment byte
    localparam logic [1:0] OSR_PFX_COLAB = 2'h0; // column, formats a/b
    localparam logic [1:0] OSR_PFX_COLC  = 2'h1; // column, format c
    localparam int         OSR_ATTR_BIT  = 5;    // 101 vs 100

    // ************************************************************
    // storage map
    // ************************************************************
    localparam logic [1:0] OSR_BLK_DISP  = 2'h0;
    localparam logic [1:0] OSR_BLK_ATTR  = 2'h1;
    localparam logic [1:0] OSR_BLK_FONT  = 2'h2;
    localparam logic [4:0] OSR_DISP_LAST = 5'h1d; // 30 columns
    localparam logic [4:0] OSR_ATTR_LAST = 5'h1e; // row attr at col 30
    localparam logic [4:0] OSR_FONT_LAST = 5'h0f; // 16 lines
    localparam int         OSR_ADDR_W    = 11;
    localparam int         OSR_MEM_WORDS = 2048;
    localparam logic [3:0] OSR_CTRL_ROW  = 4'hf;
    localparam logic [4:0] OSR_CTRL_COL  = 5'h1c;
    localparam int         OSR_EN_BIT    = 7;
    localparam int         OSR_FIFO_DEPTH = 2;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [OSR_ADDR_W-1:0] addr; // {block, row/seg, col/line}
        logic [7:0]            data;
    } osr_wr_type;

    typedef enum logic [1:0] {OSR_LK_IDLE, OSR_LK_ADDR, OSR_LK_DATA,
                              OSR_LK_SKIP} osr_link_type;
    typedef enum logic [2:0] {OSR_PS_ROW, OSR_PS_COL, OSR_PS_DATA,
                              OSR_PS_AFTER, OSR_PS_STREAM} osr_parse_type;
    typedef enum logic [1:0] {OSR_K_ROW, OSR_K_COLAB,
                              OSR_K_COLC} osr_kind_type;

endpackage
`default_nettype wire

//--- test/osr_host_model.sv
// host controller model: master side of the two-wire and spi links
`timescale 1ns/1ps
`default_nettype none
module osr_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output var logic  scl,
    output var logic  sda_drv,
    output var logic  ss_n
);
    // ****************************************************
    // idle state: both wires released to their pull-ups
    // ****************************************************
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        ss_n = 1'b1; // select stays high outside spi frames
    end

    // half a link period: 8 cycles, so one bit takes 160 ns
    task automatic half();
        repeat (8) @(posedge clk);
    endtask

    // data moves 2 cycles after the fall so it never looks like a stop
    task automatic clock_bit(input logic b, output logic seen);
        repeat (2) @(posedge clk);
        sda_drv <= b;
        repeat (6) @(posedge clk);
        scl <= 1'b1;
        half();
        seen = sda_line;
        scl <= 1'b0;
    endtask

    // start: data falls while the clock stands high
    task automatic start_cond();
        @(posedge clk);
        sda_drv <= 1'b1;
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
    endtask

    // eight bits msb first, then a released ninth clock for the ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], dummy);
        end
        clock_bit(1'b1, ack);
    endtask

    // stop: data rises while the clock stands high, then idle
    task automatic stop_cond();
        repeat (2) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (6) @(posedge clk);
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask

    // spi frame: clock parked low first, so the two-wire side sees
    // no start or stop; sel low clocks the bits with select left high
    task automatic spi_frame(input logic [7:0] q[$], input logic sel);
        logic dummy;
        @(posedge clk);
        scl <= 1'b0;
        half();
        ss_n <= !sel;
        half();
        foreach (q[i]) begin
            for (int j = 7; j >= 0; j--) begin
                clock_bit(q[i][j], dummy);
            end
        end
        half();
        ss_n <= 1'b1;
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
    endtask
endmodule
`default_nettype wire

//--- test/osr_serial_host_receiver_bench.sv
// self-checking bench for the serial receiver, two-wire and spi builds
`timescale 1ns/1ps
`default_nettype none
module osr_serial_host_receiver_bench
    import osr_pkg::*;
;
    // one table row: row byte, column byte, data, storage address
    typedef struct packed {
        logic [7:0]  r;
        logic [7:0]  c;
        logic [7:0]  d;
        logic [10:0] a;
    } osr_row_type;

    localparam osr_row_type ROWS [5] = '{
        '{8'h80, 8'h00, 8'h11, {2'h0, 4'h0, 5'h00}},
        '{8'h8e, 8'h1d, 8'h22, {2'h0, 4'he, 5'h1d}},
        '{8'ha3, 8'h1e, 8'h33, {2'h1, 4'h3, 5'h1e}},
        '{8'hcf, 8'h0f, 8'h44, {2'h2, 4'hf, 5'h0f}},
        '{8'h95, 8'h25, 8'h55, {2'h0, 4'h5, 5'h05}}};

    logic        clk = 1'b0;
    logic        reset_n;
    logic        scl;
    logic        sda_drv;
    logic        ss_n;
    logic        sda_pin_out;
    logic        sda_pin_oe_n;
    logic        rd_req;
    logic [10:0] rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        display_enable_bit;
    logic        sda_oe_n_spi;
    logic [7:0]  rd_data_spi;
    logic        rd_valid_spi;
    int          n_mismatch;
    int          check_count;
    wire  logic  sda_line;

    // open-drain wire: low while the receiver drives, else host/pull-up
    assign sda_line = sda_pin_oe_n ? sda_drv : sda_pin_out;

    always #5 clk = ~clk;

    osr_receiver u_osr_receiver (.clk(clk), .reset_n(reset_n), .ce(1'b1),
        .scl_pin(scl), .sda_pin_in(sda_line), .sda_pin_out(sda_pin_out),
        .sda_pin_oe_n(sda_pin_oe_n), .ss_n_pin(ss_n), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .display_enable_bit(display_enable_bit));

    // spi build on the same wires; it must ignore all two-wire traffic
    osr_receiver #(.SPI_MODE(1'b1)) u_osr_receiver_spi (.clk(clk),
        .reset_n(reset_n), .ce(1'b1), .scl_pin(scl), .sda_pin_in(sda_line),
        .sda_pin_out(), .sda_pin_oe_n(sda_oe_n_spi), .ss_n_pin(ss_n),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data_spi),
        .rd_valid(rd_valid_spi), .display_enable_bit());

    osr_host_model u_osr_host_model (.clk(clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv), .ss_n(ss_n));

    // ****************************************************
    // compare, read and transfer helpers
    // ****************************************************
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask

    // one refresh read; answer lands one edge after the request
    task automatic rd_chk(input logic [10:0] a, input logic [7:0] exp,
                          input logic spi = 1'b0);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        chk_bit(spi ? rd_valid_spi : rd_valid, 1'b1);
        chk_byte(spi ? rd_data_spi : rd_data, exp);
    endtask

    // whole transfer; a refused address gets no data and an early stop
    task automatic xfer(input logic [7:0] adr, input logic [7:0] q[$],
                        input logic want);
        logic ack;
        u_osr_host_model.start_cond();
        u_osr_host_model.put_byte(adr, ack);
        chk_bit(ack, !want);
        if (want) begin
            foreach (q[i]) begin
                u_osr_host_model.put_byte(q[i], ack);
                chk_bit(ack, 1'b0);
            end
        end
        u_osr_host_model.stop_cond();
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about 9400 cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        n_mismatch = 0;
        check_count = 0;
        reset_n = 1'b0;
        rd_req = 1'b0;
        rd_addr = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk_bit(sda_pin_oe_n, 1'b1);
        chk_bit(display_enable_bit, 1'b0);
        chk_bit(rd_valid, 1'b0);
        repeat (4) @(posedge clk);
        // format a, one explicit location per data byte, every block
        foreach (ROWS[i]) begin
            xfer(OSR_CHIP_ADDR, '{ROWS[i].r, ROWS[i].c, ROWS[i].d},
                 1'b1);
            rd_chk(ROWS[i].a, ROWS[i].d);
        end
        // foreign address: no acknowledge
        xfer(8'h7c, '{8'h80}, 1'b0);
        // format b: column or row may follow a data byte
        xfer(OSR_CHIP_ADDR, '{8'h81, 8'h02, 8'hd0, 8'h03, 8'hd1, 8'h84,
                              8'h01, 8'hd2}, 1'b1);
        rd_chk({2'h0, 4'h1, 5'h02}, 8'hd0);
        rd_chk({2'h0, 4'h1, 5'h03}, 8'hd1);
        rd_chk({2'h0, 4'h4, 5'h01}, 8'hd2);
        // format c across the column wrap; a column-like byte is data
        xfer(OSR_CHIP_ADDR, '{8'h86, 8'h5c, 8'he0, 8'he1, 8'he2, 8'h02},
             1'b1);
        rd_chk({2'h0, 4'h6, 5'h1c}, 8'he0);
        rd_chk({2'h0, 4'h6, 5'h1d}, 8'he1);
        rd_chk({2'h0, 4'h7, 5'h00}, 8'he2);
        rd_chk({2'h0, 4'h7, 5'h01}, 8'h02);
        // after stop the parser wants a row byte again
        xfer(OSR_CHIP_ADDR, '{8'h87, 8'h01, 8'h99}, 1'b1);
        rd_chk({2'h0, 4'h7, 5'h01}, 8'h99);
        // enable bit only after its control byte is written
        chk_bit(display_enable_bit, 1'b0);
        xfer(OSR_CHIP_ADDR, '{8'haf, 8'h1c, 8'h80}, 1'b1);
        chk_bit(display_enable_bit, 1'b1);
        // refresh reads hold the storage for the whole transfer
        fork
            xfer(OSR_CHIP_ADDR, '{8'h89, 8'h40, 8'ha1, 8'ha2}, 1'b1);
            begin
                @(posedge clk);
                rd_req <= 1'b1;
                rd_addr <= {2'h0, 4'h1, 5'h02};
                repeat (800) begin
                    @(posedge clk);
                    #1;
                    chk_bit(rd_valid, 1'b1);
                    chk_byte(rd_data, 8'hd0);
                end
                @(posedge clk);
                rd_req <= 1'b0;
            end
        join
        // buffered words must all land once the reader lets go
        rd_chk({2'h0, 4'h9, 5'h00}, 8'ha1);
        rd_chk({2'h0, 4'h9, 5'h01}, 8'ha2);
        // spi build: no address byte, select frames every transfer
        u_osr_host_model.spi_frame('{8'h8a, 8'h03, 8'h5a, 8'h05, 8'h5e},
                                   1'b1);
        u_osr_host_model.spi_frame('{8'h8a, 8'h05, 8'h3c}, 1'b0);
        // leading column byte must be dropped: parser wants a row again
        u_osr_host_model.spi_frame('{8'h05, 8'h8b, 8'h04, 8'h6b},
                                   1'b1);
        chk_bit(sda_oe_n_spi, 1'b1);
        rd_chk({2'h0, 4'ha, 5'h03}, 8'h5a, 1'b1);
        rd_chk({2'h0, 4'ha, 5'h05}, 8'h5e, 1'b1);
        rd_chk({2'h0, 4'hb, 5'h04}, 8'h6b, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
